//--- src/dmc_pkg.sv
// Package: offsets, field layout, reset values and commands of the memory configuration block
package dmc_pkg;
	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [15:0] MEM_CONFIG_ADDR    = 16'h8000;
	localparam logic [15:0] SYS_CTRL_LAST_ADDR = 16'h8007;
	localparam logic [15:0] STATUS_ADDR        = 16'h8010;
	localparam logic [15:0] BLOCK_CTRL_ADDR    = 16'h8011;
	localparam logic [7:0]  MEM_CONFIG_RESET   = 8'h10;
	localparam logic [7:0]  MEM_CONFIG_USED    = 8'h3f;
	localparam logic [7:0]  BLOCK_CTRL_RESET   = 8'h00;

	// ***************************************************************
	// Field positions of memory_configuration
	// ***************************************************************
	localparam int GLYPH_SOURCE_BIT = 0;
	localparam int GLYPH_HEIGHT_BIT = 2;
	localparam int PANEL_DUAL_BIT   = 3;
	localparam int RESERVED4_BIT    = 4;
	localparam int ORIGIN_COMP_BIT  = 5;

	// ***************************************************************
	// Glyph heights and scroll range
	// ***************************************************************
	localparam logic [4:0] GLYPH_HEIGHT_SHORT = 5'h08;
	localparam logic [4:0] GLYPH_HEIGHT_TALL  = 5'h10;
	localparam logic [2:0] SCROLL_MAX         = 3'h7;

	// ***************************************************************
	// Configure-display parameter count
	// ***************************************************************
	localparam logic [2:0] CONFIG_PARAM_LAST = 3'h7;

	// ***************************************************************
	// Timing restart sequencer
	// ***************************************************************
	typedef enum logic [1:0] {
		DMC_RUN     = 2'b00,
		DMC_RESTART = 2'b01,
		DMC_BLANK   = 2'b10
	} dmc_seq_type;
endpackage

//--- src/dmc_layer_offset.sv
// Text layer placement against the graphics layer
`timescale 1ns/1ns
module dmc_layer_offset (
	// Settings
	input  wire logic       originCompN,
	input  wire logic       glyphFromRam,
	input  wire logic [2:0] pixelScroll,
	// Offsets
	output logic            textRowShift,
	output logic [2:0]      textColShift
);
	always_comb begin
		// User glyphs never get the row shift; software pre-shifts their bitmaps
		textRowShift = !originCompN && !glyphFromRam;
		textColShift = pixelScroll;
	end
endmodule

//--- src/dmc_memory_config.sv
// Memory configuration register and configure-display parameter load
//
// Behaviour
// - Bits marked not applicable are ignored and read back as zero.
// - Writing memory configuration restarts display timing and turns display off.
// - In indirect mode, that write also leaves power save.
// - Configure-display command carries system control registers 00h..07h in order.
// - Bit 5 zero enables origin compensation, one disables it.
// - Origin compensation shifts text layer down one row against graphics.
// - Pixel scroll moves text layer right by 1 to 7 pixels.
// - Origin compensation never shifts user glyph RAM characters.
// - Register resets to 10h; reserved bit 4 defaults to one.
// - Bit 3 selects single (0) or dual (1) STN panel drive.
// - Fourth block start pointer used only in dual-panel drive.
// - Cursor moves continuously over whole screen in all supported arrangements.
// - Bit 2 selects glyph height: 0 gives 8, 1 gives 16 pixels.
// - Bit 0 selects fixed glyph ROM (0) or user glyph RAM (1).
`timescale 1ns/1ns
module dmc_memory_config #(
	parameter int RESTART_CYCLES = 4
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [15:0] regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdData_q,
	// Configure-display command parameter stream
	input  wire logic        cfgParamValid,
	input  wire logic [7:0]  cfgParamData,
	input  wire logic        cfgCmdStart,
	// Mode and state
	input  wire logic        indirectMode,
	input  wire logic        powerSaveReq,
	input  wire logic [2:0]  pixelScroll,
	// Display control
	output logic             timingReset_q,
	output logic             displayOff_q,
	output logic             powerSave_q,
	output logic             textRowShift_q,
	output logic      [2:0]  textColShift_q,
	output logic      [4:0]  glyphHeight_q,
	output logic             glyphFromRam_q,
	output logic             dualPanel_q,
	output logic             block4Enable_q,
	output logic             cursorContinuous_q,
	output logic      [7:0]  sysParamAddr_q,
	output logic             sysParamWrite_q,
	output logic      [7:0]  sysParamData_q
);
	// ***************************************************************
	// Storage
	// ***************************************************************
	logic [7:0]               memConfig_q;
	logic [2:0]               paramIdx_q;
	logic                     paramActive_q;
	dmc_pkg::dmc_seq_type     seq_q;
	logic [7:0]               seqCnt_q;
	logic                     blockCtrl_q;
	logic                     memCfgLoad;
	logic [7:0]               memCfgNext;
	logic                     rowShift;
	logic [2:0]               colShift;

	function automatic logic [7:0] cfgMask(input logic [7:0] v);
		// Bits 7:6 not applicable: dropped on store
		return v & dmc_pkg::MEM_CONFIG_USED;
	endfunction

	// ***************************************************************
	// Register write decode
	// ***************************************************************
	logic busCfgWrite;
	logic paramCfgWrite;
	assign busCfgWrite   = regWrite && (regAddr == dmc_pkg::MEM_CONFIG_ADDR);
	// First parameter of the command lands in memory configuration
	assign paramCfgWrite = cfgParamValid && paramActive_q && (paramIdx_q == 3'h0);
	assign memCfgLoad    = busCfgWrite || paramCfgWrite;
	assign memCfgNext    = busCfgWrite ? cfgMask(regWrData) : cfgMask(cfgParamData);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			memConfig_q <= dmc_pkg::MEM_CONFIG_RESET;
		end else if (memCfgLoad) begin
			memConfig_q <= memCfgNext;
		end
	end

	// Scratch control bit; block 4 still follows the panel drive bit alone
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blockCtrl_q <= 1'b0;
		end else if (regWrite && regAddr == dmc_pkg::BLOCK_CTRL_ADDR) begin
			blockCtrl_q <= regWrData[0];
		end
	end

	// ***************************************************************
	// Configure-display parameter sequencing
	// ***************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			paramIdx_q    <= 3'h0;
			paramActive_q <= 1'b0;
		end else if (cfgCmdStart) begin
			paramIdx_q    <= 3'h0;
			paramActive_q <= 1'b1;
		end else if (cfgParamValid && paramActive_q) begin
			paramIdx_q    <= paramIdx_q + 3'h1;
			paramActive_q <= (paramIdx_q != dmc_pkg::CONFIG_PARAM_LAST);
		end
	end

	// Parameters 1..7 forwarded to the neighbouring system registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sysParamAddr_q  <= 8'h00;
			sysParamWrite_q <= 1'b0;
			sysParamData_q  <= 8'h00;
		end else begin
			sysParamWrite_q <= cfgParamValid && paramActive_q && (paramIdx_q != 3'h0);
			if (cfgParamValid && paramActive_q) begin
				sysParamAddr_q <= {5'h00, paramIdx_q};
				sysParamData_q <= cfgParamData;
			end
		end
	end

	// ***************************************************************
	// Timing restart and blanking
	// ***************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seq_q         <= dmc_pkg::DMC_RUN;
			seqCnt_q      <= 8'h00;
			timingReset_q <= 1'b0;
			displayOff_q  <= 1'b1;
		end else if (memCfgLoad) begin
			seq_q         <= dmc_pkg::DMC_RESTART;
			seqCnt_q      <= 8'(RESTART_CYCLES - 1);
			timingReset_q <= 1'b1;
			displayOff_q  <= 1'b1;
		end else begin
			unique case (seq_q)
				dmc_pkg::DMC_RUN: begin
					timingReset_q <= 1'b0;
				end
				dmc_pkg::DMC_RESTART: begin
					if (seqCnt_q == 8'h00) begin
						seq_q         <= dmc_pkg::DMC_BLANK;
						timingReset_q <= 1'b0;
					end else begin
						seqCnt_q <= seqCnt_q - 8'h01;
					end
				end
				dmc_pkg::DMC_BLANK: begin
					// Display stays off until software enables it elsewhere
					seq_q <= dmc_pkg::DMC_RUN;
				end
				default: begin
					seq_q <= dmc_pkg::DMC_RUN;
				end
			endcase
		end
	end

	// ***************************************************************
	// Power save
	// ***************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			powerSave_q <= 1'b0;
		end else if (memCfgLoad && indirectMode) begin
			powerSave_q <= 1'b0;
		end else if (powerSaveReq) begin
			powerSave_q <= 1'b1;
		end
	end

	// ***************************************************************
	// Decoded modes
	// ***************************************************************
	dmc_layer_offset offsets (
		.originCompN  (memConfig_q[dmc_pkg::ORIGIN_COMP_BIT]),
		.glyphFromRam (memConfig_q[dmc_pkg::GLYPH_SOURCE_BIT]),
		.pixelScroll  (pixelScroll),
		.textRowShift (rowShift),
		.textColShift (colShift)
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			// Register reset contents leave compensation on
			textRowShift_q     <= 1'b1;
			textColShift_q     <= 3'h0;
			glyphHeight_q      <= dmc_pkg::GLYPH_HEIGHT_SHORT;
			glyphFromRam_q     <= 1'b0;
			dualPanel_q        <= 1'b0;
			block4Enable_q     <= 1'b0;
			cursorContinuous_q <= 1'b1;
		end else begin
			textRowShift_q     <= rowShift;
			textColShift_q     <= colShift;
			glyphHeight_q      <= memConfig_q[dmc_pkg::GLYPH_HEIGHT_BIT] ?
				dmc_pkg::GLYPH_HEIGHT_TALL : dmc_pkg::GLYPH_HEIGHT_SHORT;
			glyphFromRam_q     <= memConfig_q[dmc_pkg::GLYPH_SOURCE_BIT];
			dualPanel_q        <= memConfig_q[dmc_pkg::PANEL_DUAL_BIT];
			block4Enable_q     <= memConfig_q[dmc_pkg::PANEL_DUAL_BIT];
			// Only single and above-and-below arrangements exist here
			cursorContinuous_q <= 1'b1;
		end
	end

	// ***************************************************************
	// Read port
	// ***************************************************************
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			regRdData_q <= 8'h00;
		end else if (regRead) begin
			unique case (regAddr)
				dmc_pkg::MEM_CONFIG_ADDR: regRdData_q <= memConfig_q;
				dmc_pkg::STATUS_ADDR:
					regRdData_q <= {4'h0, paramActive_q, powerSave_q, timingReset_q,
						displayOff_q};
				dmc_pkg::BLOCK_CTRL_ADDR: regRdData_q <= {7'h00, blockCtrl_q};
				default:                  regRdData_q <= 8'h00;
			endcase
		end else begin
			regRdData_q <= 8'h00;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	// Repetition counts below assume the default restart length of four
	chk_write_restarts: assert property (@(posedge sys_clk) disable iff (rst)
		memCfgLoad |=> timingReset_q && displayOff_q)
		else $error("Config write did not restart timing");
	chk_restart_held: assert property (@(posedge sys_clk) disable iff (rst)
		memCfgLoad ##1 !memCfgLoad [*4] |-> timingReset_q)
		else $error("Timing reset dropped early");
	chk_restart_ends: assert property (@(posedge sys_clk) disable iff (rst)
		memCfgLoad ##1 !memCfgLoad [*4] |=> !timingReset_q)
		else $error("Timing reset held too long");
	chk_timing_idle: assert property (@(posedge sys_clk) disable iff (rst)
		(seq_q == dmc_pkg::DMC_RUN) && !memCfgLoad |=> !timingReset_q)
		else $error("Timing reset while running");
	chk_power_exit: assert property (@(posedge sys_clk) disable iff (rst)
		memCfgLoad && indirectMode |=> !powerSave_q)
		else $error("Power save not left");
	chk_na_bits_zero: assert property (@(posedge sys_clk) disable iff (rst)
		memConfig_q[7:6] == 2'b00)
		else $error("Not-applicable bits stored");
	chk_na_read: assert property (@(posedge sys_clk) disable iff (rst)
		regRead && (regAddr == dmc_pkg::MEM_CONFIG_ADDR) |=> regRdData_q[7:6] == 2'b00)
		else $error("Not-applicable bits read back");
	chk_height_map: assert property (@(posedge sys_clk) disable iff (rst)
		$past(memConfig_q[dmc_pkg::GLYPH_HEIGHT_BIT]) |-> glyphHeight_q == 5'h10)
		else $error("Glyph height wrong");
	chk_height_short: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(memConfig_q[dmc_pkg::GLYPH_HEIGHT_BIT]) |-> glyphHeight_q == 5'h08)
		else $error("Short glyph height wrong");
	chk_row_shift: assert property (@(posedge sys_clk) disable iff (rst)
		textRowShift_q |-> !$past(memConfig_q[5]) && !$past(memConfig_q[0]))
		else $error("Row shift with compensation off or RAM glyphs");
	chk_row_shift_on: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(memConfig_q[5]) && !$past(memConfig_q[0]) |-> textRowShift_q)
		else $error("Row shift missing with compensation on");
	chk_col_shift: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(rst) |-> textColShift_q == $past(pixelScroll))
		else $error("Column shift does not follow pixel scroll");
	chk_block4_dual: assert property (@(posedge sys_clk) disable iff (rst)
		block4Enable_q == $past(memConfig_q[3]))
		else $error("Block 4 use does not follow panel drive");
	chk_param_first: assert property (@(posedge sys_clk) disable iff (rst)
		cfgCmdStart ##1 (cfgParamValid && !cfgCmdStart && !regWrite)
		|=> memConfig_q == cfgMask($past(cfgParamData)))
		else $error("First parameter not loaded");
	chk_param_fwd: assert property (@(posedge sys_clk) disable iff (rst)
		cfgParamValid && paramActive_q && (paramIdx_q != 3'h0) |=> sysParamWrite_q &&
		(sysParamAddr_q == {5'h00, $past(paramIdx_q)}) && (sysParamData_q == $past(cfgParamData)))
		else $error("Parameter not forwarded");
	chk_param_count: assert property (@(posedge sys_clk) disable iff (rst)
		cfgParamValid && paramActive_q && (paramIdx_q == dmc_pkg::CONFIG_PARAM_LAST) &&
		!cfgCmdStart |=> !paramActive_q)
		else $error("Command took more than eight parameters");
	chk_param_stop: assert property (@(posedge sys_clk) disable iff (rst)
		!paramActive_q |=> !sysParamWrite_q)
		else $error("Parameter forwarded outside a command");
	chk_dual_flag: assert property (@(posedge sys_clk) disable iff (rst)
		dualPanel_q == $past(memConfig_q[3]))
		else $error("Panel drive flag wrong");
	chk_ram_select: assert property (@(posedge sys_clk) disable iff (rst)
		glyphFromRam_q == $past(memConfig_q[0]))
		else $error("Glyph source wrong");
endmodule

//--- tb/dmc_memory_config_tb.sv
// Self-checking bench for the memory configuration register block
`timescale 1ns/1ns
module dmc_memory_config_tb;
	localparam int RC = 4;
	typedef struct packed {
		logic [7:0] wr;
		logic [7:0] rd;
		logic       rowShift;
		logic [4:0] height;
	} dmc_row_type;
	logic        sys_clk;
	logic        rst;
	logic [15:0] regAddr;
	logic [7:0]  regWrData;
	logic        regWrite;
	logic        regRead;
	logic [7:0]  regRdData_q;
	logic        cfgParamValid;
	logic [7:0]  cfgParamData;
	logic        cfgCmdStart;
	logic        indirectMode;
	logic        powerSaveReq;
	logic [2:0]  pixelScroll;
	logic        timingReset_q;
	logic        displayOff_q;
	logic        powerSave_q;
	logic        textRowShift_q;
	logic [2:0]  textColShift_q;
	logic [4:0]  glyphHeight_q;
	logic        glyphFromRam_q;
	logic        dualPanel_q;
	logic        block4Enable_q;
	logic        cursorContinuous_q;
	logic [7:0]  sysParamAddr_q;
	logic        sysParamWrite_q;
	logic [7:0]  sysParamData_q;
	int          nMismatch;
	int          numChecks;
	dmc_row_type rows [5];

	dmc_memory_config #(.RESTART_CYCLES(RC)) uut (
		.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData_q(regRdData_q),
		.cfgParamValid(cfgParamValid), .cfgParamData(cfgParamData),
		.cfgCmdStart(cfgCmdStart), .indirectMode(indirectMode),
		.powerSaveReq(powerSaveReq), .pixelScroll(pixelScroll),
		.timingReset_q(timingReset_q), .displayOff_q(displayOff_q),
		.powerSave_q(powerSave_q), .textRowShift_q(textRowShift_q),
		.textColShift_q(textColShift_q), .glyphHeight_q(glyphHeight_q),
		.glyphFromRam_q(glyphFromRam_q), .dualPanel_q(dualPanel_q),
		.block4Enable_q(block4Enable_q), .cursorContinuous_q(cursorContinuous_q),
		.sysParamAddr_q(sysParamAddr_q), .sysParamWrite_q(sysParamWrite_q),
		.sysParamData_q(sysParamData_q));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic printVerdict();
		if (nMismatch == 0 && numChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
		numChecks++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s", $time, m);
			nMismatch++;
		end
	endtask

	// Returns one settle step after the edge that takes the write
	task automatic regWr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge sys_clk);
		regWrite  <= 1'b0;
		#1;
	endtask

	task automatic regRd(input logic [15:0] a, input logic [7:0] exp, input string m);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		check(regRdData_q, exp, m);
	endtask

	task automatic doReset(input int n);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (n) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		check(displayOff_q, 8'h01, "display off at reset");
		check(glyphHeight_q, 8'h08, "glyph height at reset");
		check(cursorContinuous_q, 8'h01, "cursor continuous");
		check(textRowShift_q, 8'h01, "row shift at reset");
		check(timingReset_q, 8'h00, "no restart at reset");
		check(powerSave_q, 8'h00, "power save at reset");
		regRd(dmc_pkg::MEM_CONFIG_ADDR, dmc_pkg::MEM_CONFIG_RESET, "reset value");
	endtask

	initial begin
		#20000;
		nMismatch++;
		printVerdict();
	end

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		rst = 1'b1; regAddr = 16'h0000; regWrData = 8'h00; regWrite = 1'b0;
		regRead = 1'b0; cfgParamValid = 1'b0; cfgParamData = 8'h00;
		cfgCmdStart = 1'b0; indirectMode = 1'b0; powerSaveReq = 1'b0;
		pixelScroll = 3'h0; nMismatch = 0; numChecks = 0;
		// Reserved bit 4 kept as written; bit 0 set suppresses the row shift
		rows[0] = '{8'h00, 8'h00, 1'b1, 5'h08};
		rows[1] = '{8'h2c, 8'h2c, 1'b0, 5'h10};
		rows[2] = '{8'hc1, 8'h01, 1'b0, 5'h08};
		rows[3] = '{8'h3c, 8'h3c, 1'b0, 5'h10};
		rows[4] = '{8'h1c, 8'h1c, 1'b1, 5'h10};
		doReset(20);
		// Scratch bit set: single-drive rows must still ignore block 4
		regWr(dmc_pkg::BLOCK_CTRL_ADDR, 8'h01);
		regRd(dmc_pkg::BLOCK_CTRL_ADDR, 8'h01, "block control readback");
		foreach (rows[i]) begin
			regWr(dmc_pkg::MEM_CONFIG_ADDR, rows[i].wr);
			check(timingReset_q, 8'h01, "timing restart");
			check(displayOff_q, 8'h01, "display off on write");
			@(posedge sys_clk);
			#1;
			check(textRowShift_q, rows[i].rowShift, "row shift");
			check(glyphHeight_q, rows[i].height, "glyph height");
			check(glyphFromRam_q, rows[i].rd[0], "glyph source");
			check(dualPanel_q, rows[i].rd[3], "panel drive");
			check(block4Enable_q, rows[i].rd[3], "block 4 use");
			// Restart stands RC cycles: last high cycle follows the third edge
			repeat (RC - 2) @(posedge sys_clk);
			#1;
			check(timingReset_q, 8'h01, "restart held");
			@(posedge sys_clk);
			#1;
			check(timingReset_q, 8'h00, "restart ends");
			regRd(dmc_pkg::MEM_CONFIG_ADDR, rows[i].rd, "readback");
		end
		// Unmapped place: write ignored, reads zero
		regWr(16'h8020, 8'h3f);
		regRd(16'h8020, 8'h00, "unmapped read");
		regRd(dmc_pkg::MEM_CONFIG_ADDR, 8'h1c, "unmapped write leaked");
		// Pixel scroll over values 1 to 7
		for (int s = 1; s <= 7; s++) begin
			@(posedge sys_clk);
			pixelScroll <= 3'(s);
			@(posedge sys_clk);
			#1;
			check(textColShift_q, 8'(s), "pixel scroll");
		end
		// Power save left by a write in indirect mode
		@(posedge sys_clk);
		indirectMode <= 1'b1;
		powerSaveReq <= 1'b1;
		@(posedge sys_clk);
		powerSaveReq <= 1'b0;
		#1;
		check(powerSave_q, 8'h01, "power save entry");
		regRd(dmc_pkg::STATUS_ADDR, 8'h05, "status in power save");
		regWr(dmc_pkg::MEM_CONFIG_ADDR, 8'h10);
		check(powerSave_q, 8'h00, "power save exit");
		// Configure-display parameter stream, one spare parameter after the last
		@(posedge sys_clk);
		cfgCmdStart <= 1'b1;
		@(posedge sys_clk);
		cfgCmdStart <= 1'b0;
		for (int p = 0; p < 9; p++) begin
			// First parameter follows the start strobe with no gap
			cfgParamValid <= 1'b1;
			cfgParamData  <= (p == 0) ? 8'h08 : 8'(8'h40 + p);
			@(posedge sys_clk);
			cfgParamValid <= 1'b0;
			#1;
			check(sysParamWrite_q, (p >= 1 && p <= 7), "param write");
			if (p == 0) check(timingReset_q, 8'h01, "param 0 restart");
			if (p >= 1 && p <= 7) begin
				check(sysParamAddr_q, 8'(p), "param index");
				check(sysParamData_q, 8'(8'h40 + p), "param data");
			end
			@(posedge sys_clk);
		end
		regRd(dmc_pkg::MEM_CONFIG_ADDR, 8'h08, "param 0 load");
		check(dualPanel_q, 8'h01, "dual after param");
		// Second reset in mid-run
		doReset(3);
		printVerdict();
	end
endmodule
